// ==== pecic_consts.vh ====
// constants for the pin edge-change interrupt unit
`ifndef PECIC_CONSTS_VH
`define PECIC_CONSTS_VH
`define PECIC_OFF_PA_RISE    8'h00
`define PECIC_OFF_PA_FALL    8'h04
`define PECIC_OFF_PA_FLAGS   8'h08
`define PECIC_OFF_PB_RISE    8'h0C
`define PECIC_OFF_PB_FALL    8'h10
`define PECIC_OFF_CTRL       8'h14
`define PECIC_OFF_IRQ_STAT   8'h18
`define PECIC_OFF_IRQ_MASK   8'h1C
`define PECIC_PA_MASK        8'h3F
`define PECIC_PB_MASK        8'hF0
`define PECIC_RESET_BYTE     8'h00
`define PECIC_CTRL_MEN_BIT   0
`define PECIC_STAT_SUM_BIT   0
`define PECIC_RESP_OKAY      2'b00
`define PECIC_RESP_SLVERR    2'b10
`endif

// ==== pecic_edge_det.v ====
// one pin: synchroniser and rise/fall edge pulses
`timescale 1ns/1ns
`default_nettype none
module pecic_edge_det (
   input  wire aclk,
   input  wire aresetn,
   input  wire pin_in,
   output wire rise_pulse,
   output wire fall_pulse
);
   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end
   // one-cycle pulses from successive synchronised samples
   assign rise_pulse = sync2_q & ~prev_q;
   assign fall_pulse = ~sync2_q & prev_q;
endmodule
`default_nettype wire

// ==== pecic_top.v ====
// pin edge-change interrupt unit with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "pecic_consts.vh"
module pecic_top #(
   parameter NPA = 6,
   parameter NPB = 4
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  porta_pins,
   input  wire [7:0]  portb_pins,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         change_irq_summary_flag,
   output reg         change_irq,
   output reg         wake_request,
   output reg         irq
);
   wire [7:0] pins_all = porta_pins & `PECIC_PA_MASK;
   wire [7:0] rise_a;
   wire [7:0] fall_a;
   wire [7:0] rise_b;
   wire [7:0] fall_b;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_det
         pecic_edge_det u_a (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .pin_in     (pins_all[g]),
            .rise_pulse (rise_a[g]),
            .fall_pulse (fall_a[g])
         );
         pecic_edge_det u_b (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .pin_in     (portb_pins[g]),
            .rise_pulse (rise_b[g]),
            .fall_pulse (fall_b[g])
         );
      end
   endgenerate

   reg  [7:0] porta_rise_enable_q;
   reg  [7:0] porta_fall_enable_q;
   reg  [7:0] porta_change_flags_q;
   reg  [7:0] portb_rise_enable_q;
   reg  [7:0] portb_fall_enable_q;
   reg  [7:0] portb_change_flags_q;
   reg        change_irq_master_enable_q;
   reg        irq_stat_q;
   reg        irq_mask_q;

   // both enables set gives both polarities
   wire [7:0] hit_a = ((rise_a & porta_rise_enable_q)
                     | (fall_a & porta_fall_enable_q)) & `PECIC_PA_MASK;
   wire [7:0] hit_b = ((rise_b & portb_rise_enable_q)
                     | (fall_b & portb_fall_enable_q)) & `PECIC_PB_MASK;
   wire       any_hit = |{hit_a, hit_b};

   // write channel: address and data taken in either order
   reg        aw_held_q;
   reg        w_held_q;
   reg  [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg  [3:0] w_strb_q;
   wire       aw_fire = s_axi_awvalid & s_axi_awready;
   wire       w_fire  = s_axi_wvalid & s_axi_wready;
   wire       aw_have = aw_held_q | aw_fire;
   wire       w_have  = w_held_q | w_fire;
   wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
   wire       wr_lane0 = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];
   wire       wr_go   = aw_have & w_have & ~s_axi_bvalid;
   wire       wr_en   = wr_go & wr_lane0;
   wire [7:0] wb      = wr_data[7:0];
   reg        wr_hit;

   always @* begin
      case (wr_addr)
         `PECIC_OFF_PA_RISE,
         `PECIC_OFF_PA_FALL,
         `PECIC_OFF_PA_FLAGS,
         `PECIC_OFF_PB_RISE,
         `PECIC_OFF_PB_FALL,
         `PECIC_OFF_CTRL,
         `PECIC_OFF_IRQ_STAT,
         `PECIC_OFF_IRQ_MASK: wr_hit = 1'b1;
         default:             wr_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PECIC_RESP_OKAY;
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
      end else begin
         if (aw_fire) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         s_axi_awready <= ~aw_have & ~s_axi_awready;
         s_axi_wready  <= ~w_have & ~s_axi_wready;
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PECIC_RESP_OKAY : `PECIC_RESP_SLVERR;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // enable and control registers: next values first, then the flops
   reg  [7:0] porta_rise_enable_d;
   reg  [7:0] porta_fall_enable_d;
   reg  [7:0] portb_rise_enable_d;
   reg  [7:0] portb_fall_enable_d;
   reg        change_irq_master_enable_d;
   reg        irq_mask_d;

   always @* begin
      porta_rise_enable_d        = porta_rise_enable_q;
      porta_fall_enable_d        = porta_fall_enable_q;
      portb_rise_enable_d        = portb_rise_enable_q;
      portb_fall_enable_d        = portb_fall_enable_q;
      change_irq_master_enable_d = change_irq_master_enable_q;
      irq_mask_d                 = irq_mask_q;
      if (wr_en) begin
         case (wr_addr)
            `PECIC_OFF_PA_RISE:
               porta_rise_enable_d = wb & `PECIC_PA_MASK;
            `PECIC_OFF_PA_FALL:
               porta_fall_enable_d = wb & `PECIC_PA_MASK;
            `PECIC_OFF_PB_RISE:
               portb_rise_enable_d = wb & `PECIC_PB_MASK;
            `PECIC_OFF_PB_FALL:
               portb_fall_enable_d = wb & `PECIC_PB_MASK;
            `PECIC_OFF_CTRL:
               change_irq_master_enable_d = wb[`PECIC_CTRL_MEN_BIT];
            `PECIC_OFF_IRQ_MASK:
               irq_mask_d = wb[`PECIC_STAT_SUM_BIT];
            default: ;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         porta_rise_enable_q <= `PECIC_RESET_BYTE;
         porta_fall_enable_q <= `PECIC_RESET_BYTE;
         portb_rise_enable_q <= `PECIC_RESET_BYTE;
         portb_fall_enable_q <= `PECIC_RESET_BYTE;
         change_irq_master_enable_q <= 1'b0;
         irq_mask_q <= 1'b0;
      end else begin
         porta_rise_enable_q <= porta_rise_enable_d;
         porta_fall_enable_q <= porta_fall_enable_d;
         portb_rise_enable_q <= portb_rise_enable_d;
         portb_fall_enable_q <= portb_fall_enable_d;
         change_irq_master_enable_q <= change_irq_master_enable_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // port a flags: write zero clears, write one keeps; a new edge always wins
   wire       wr_fa   = wr_en & (wr_addr == `PECIC_OFF_PA_FLAGS);
   wire       wr_stat = wr_en & (wr_addr == `PECIC_OFF_IRQ_STAT);
   reg  [7:0] porta_change_flags_d;
   reg  [7:0] portb_change_flags_d;
   reg        irq_stat_d;
   reg        summary_d;

   always @* begin
      porta_change_flags_d = porta_change_flags_q;
      if (wr_fa) begin
         porta_change_flags_d = porta_change_flags_q & wb;
      end
      // edge or-ed in last, so it survives a clearing write
      porta_change_flags_d = (porta_change_flags_d | hit_a) & `PECIC_PA_MASK;
      // port b flags have no register: once set, summary stays up
      portb_change_flags_d = (portb_change_flags_q | hit_b) & `PECIC_PB_MASK;
      irq_stat_d = irq_stat_q;
      if (wr_stat & wb[`PECIC_STAT_SUM_BIT]) begin
         irq_stat_d = 1'b0;
      end
      // set wins over a write-one clear in the same cycle
      if (any_hit & change_irq_master_enable_q) begin
         irq_stat_d = 1'b1;
      end
      summary_d = |{porta_change_flags_q, portb_change_flags_q};
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         porta_change_flags_q <= `PECIC_RESET_BYTE;
         portb_change_flags_q <= `PECIC_RESET_BYTE;
      end else begin
         // sticky, set regardless of master enable
         porta_change_flags_q <= porta_change_flags_d;
         portb_change_flags_q <= portb_change_flags_d;
      end
   end

   // summary, cpu request and wake all from registered state
   reg        any_hit_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         change_irq_summary_flag <= 1'b0;
         change_irq   <= 1'b0;
         any_hit_q    <= 1'b0;
         wake_request <= 1'b0;
         irq_stat_q   <= 1'b0;
         irq          <= 1'b0;
      end else begin
         change_irq_summary_flag <= summary_d;
         change_irq <= summary_d & change_irq_master_enable_q;
         // hit delayed one cycle so wake rises in the same cycle as the summary flag
         any_hit_q    <= any_hit;
         wake_request <= any_hit_q & change_irq_master_enable_q;
         irq_stat_q   <= irq_stat_d;
         irq          <= irq_stat_q & irq_mask_q;
      end
   end

   // read channel: one word per request, answer one cycle after arvalid
   reg [7:0] rd_byte;
   reg       rd_hit;
   always @* begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `PECIC_OFF_PA_RISE:  rd_byte = porta_rise_enable_q;
         `PECIC_OFF_PA_FALL:  rd_byte = porta_fall_enable_q;
         `PECIC_OFF_PA_FLAGS: rd_byte = porta_change_flags_q;
         `PECIC_OFF_PB_RISE:  rd_byte = portb_rise_enable_q;
         `PECIC_OFF_PB_FALL:  rd_byte = portb_fall_enable_q;
         `PECIC_OFF_CTRL:
            rd_byte = {6'h00, change_irq_summary_flag,
                       change_irq_master_enable_q};
         `PECIC_OFF_IRQ_STAT: rd_byte = {7'h00, irq_stat_q};
         `PECIC_OFF_IRQ_MASK: rd_byte = {7'h00, irq_mask_q};
         default: begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // read handshake: one read in flight at a time
   localparam RD_IDLE = 1'b0;
   localparam RD_RESP = 1'b1;
   reg        rd_state_q;
   reg        rd_state_d;

   always @* begin
      rd_state_d = rd_state_q;
      case (rd_state_q)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rd_state_d = RD_RESP;
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_d = RD_IDLE;
            end
         end
         default: rd_state_d = RD_IDLE;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q    <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PECIC_RESP_OKAY;
      end else begin
         rd_state_q    <= rd_state_d;
         // address taken as the data appears; the master holds araddr
         s_axi_arready <= 1'b0;
         if ((rd_state_q == RD_IDLE) & s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_hit ? `PECIC_RESP_OKAY
                                    : `PECIC_RESP_SLVERR;
         end else if ((rd_state_q == RD_RESP) & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== pecic_assertions.sv ====
// port-level checker for the pin edge-change unit
`timescale 1ns/1ns
`default_nettype none
module pecic_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        change_irq_summary_flag,
   input wire logic        change_irq,
   input wire logic        wake_request,
   input wire logic        irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_irq_from_summary: assert property (change_irq |->
      change_irq_summary_flag) else $error("irq without summary");
   a_wake_sets_flag: assert property (wake_request |->
      change_irq_summary_flag && change_irq) else $error("wake no flag");
   a_reset_clears: assert property ($rose(aresetn) |->
      !change_irq_summary_flag && !irq && !change_irq)
      else $error("outputs set after reset");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   a_rdata_upper: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
   a_bresp_legal: assert property (s_axi_bvalid |->
      s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10) else $error("bad bresp");
   a_arready_pulse: assert property (s_axi_arready |->
      s_axi_rvalid && !$past(s_axi_rvalid)) else $error("arready misplaced");
   a_read_latency: assert property (s_axi_arvalid && !s_axi_rvalid &&
      !s_axi_arready |=> s_axi_arready) else $error("read answer late");
endmodule
`default_nettype wire

// ==== pecic_pin_model.sv ====
// pads and wake counter standing in for the far side
`timescale 1ns/1ns
`default_nettype none
module pecic_pin_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] next_a,
   input  wire logic [7:0] next_b,
   input  wire logic       wake_request,
   output var  logic [7:0] porta_pins,
   output var  logic [7:0] portb_pins,
   output var  logic [7:0] wake_cnt
);
   // pads move on the clock so each change is one clean edge
   always @(posedge aclk) begin
      porta_pins <= next_a;
      portb_pins <= next_b;
      if (!aresetn) wake_cnt <= 8'h00;
      else wake_cnt <= wake_cnt + {7'h00, wake_request};
   end
endmodule
`default_nettype wire

// ==== pin_edge_change_interrupt_tb.sv ====
// self-checking bench for the pin edge-change unit
`timescale 1ns/1ns
`default_nettype none
module pin_edge_change_interrupt_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] pa, pb, awaddr, araddr, fa, ra, fl, d, ca;
   logic [3:0] ws, wst;
   logic [31:0] wdata;
   logic [15:0] lf;
   wire logic [7:0] pina, pinb, wcnt;
   wire logic awready, wready, bvalid, arready, rvalid, sum, cirq, wake, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int n_fail, checked, cyc, i;
   pecic_top DUT (.aclk(aclk), .aresetn(aresetn), .porta_pins(pina),
      .portb_pins(pinb), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wst),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .change_irq_summary_flag(sum), .change_irq(cirq),
      .wake_request(wake), .irq(irq));
   pecic_pin_model u_pins (.aclk(aclk), .aresetn(aresetn), .next_a(pa),
      .next_b(pb), .wake_request(wake), .porta_pins(pina),
      .portb_pins(pinb), .wake_cnt(wcnt));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      wst <= ws;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, 2'b00);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[7:0];
      chk(rresp, e);
      chk(rdata[31:8], 24'h000000);
   endtask
   // pin move, then wait out the sync and flag latency
   task automatic mv(input logic [7:0] na, input logic [7:0] nb);
      @(posedge aclk);
      pa <= na;
      pb <= nb;
      fa = fa | (((~ca & na & ra) | (ca & ~na & fl)) & 8'h3F);
      ca = na;
      repeat (8) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {pa, pb, awaddr, araddr, fa, ra, fl, ca, wdata} = 0;
      lf = 16'd33848;
      {n_fail, checked} = 0;
      {ws, wst} = 8'hFF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(i * 4, 2'b00);
         chk(d, 8'h00);
      end
      rd(8'h20, 2'b10);
      chk(d, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 2'b00);
      chk(d, 8'h3F);
      ws = 4'h0;
      wr(8'h00, 8'h00);
      ws = 4'hF;
      rd(8'h00, 2'b00);
      chk(d, 8'h3F);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, 2'b00);
      chk(d, 8'hF0);
      wr(8'h0C, 8'h00);
      // master enable left clear: flags must still set
      for (i = 0; i < 48; i++) begin
         lf = lfsr(lf);
         if (i % 6 == 0) begin
            ra = lf[7:0] & 8'h3F;
            fl = lf[15:8] & 8'h3F;
            wr(8'h00, ra);
            wr(8'h04, fl);
         end
         mv(lf[7:0] ^ lf[15:8], 8'h00);
         rd(8'h08, 2'b00);
         chk(d, fa);
         chk({sum, cirq}, {|fa, 1'b0});
         wr(8'h08, lf[11:4]);
         fa = fa & lf[11:4];
      end
      mv(8'h00, 8'h00);
      rd(8'h08, 2'b00);
      chk(d, fa);
      wr(8'h08, d ^ 8'hFF);
      fa = 8'h00;
      chk(wcnt, 8'h00);
      rd(8'h08, 2'b00);
      chk({d, sum}, 9'h000);
      wr(8'h14, 8'h01);
      wr(8'h1C, 8'h01);
      ra = 8'h01;
      fl = 8'h00;
      wr(8'h00, ra);
      wr(8'h04, fl);
      mv(8'h01, 8'h00);
      chk({wcnt, cirq, irq}, 10'h007);
      wr(8'h18, 8'h01);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(8'h1C, 8'h00);
      mv(8'h00, 8'h00);
      mv(8'h01, 8'h00);
      rd(8'h18, 2'b00);
      chk({d, irq, wcnt}, 17'h00202);
      wr(8'h08, 8'h00);
      repeat (2) @(posedge aclk);
      chk(sum, 1'b0);
      wr(8'h0C, 8'h80);
      mv(8'h01, 8'h80);
      chk(sum, 1'b1);
      conclude();
   end
endmodule
bind pecic_top pecic_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .change_irq_summary_flag(change_irq_summary_flag),
   .change_irq(change_irq), .wake_request(wake_request), .irq(irq));
`default_nettype wire
